// ===== apm_adc_power_mode_sequencer.sv
// Power-mode sequencer and serial result framing of a dual ADC.
// Assumes the host drives chip select and the serial clock, and that the
// conversion core holds both results stable for the whole frame.
`timescale 1ns/1ps

// Operation
// - Keep normal, partial and full power-down, picked by chip select rise.
// - A chip select fall starts a conversion; the edge count is held clear while chip select is high.
// - Rise between edges ten and fourteen aborts, stays powered, floats outputs.
// - Fourteen cycles give a result; output keeps driving until the rise.
// - Two further cycles shift out two trailing zero bits.
// - A further fourteen or sixteen cycles present the other result.
// - Active output floats on edge thirty-two or an earlier rise.
// - From normal, a rise at edges two to nine enters partial power-down.
// - From normal, a rise before edge two keeps normal mode.
// - A dummy frame past edge ten wakes partial power-down in 1 us.
// - From partial, a rise before edge two keeps partial power-down.
// - From partial, a rise at edges two to nine enters full power-down.
// - A dummy frame past edge ten wakes full power-down, then waits.
// - A serial clock fall coincident with the chip select fall is ignored.
module apm_adc_power_mode_sequencer #(
    parameter int FULL_WAKE_CYCLES = apm_pkg::APM_FULL_WAKE_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic converter_serial_clock,
    input wire logic chip_select_n,
    input wire apm_pkg::apm_result_s conv_result,
    output logic result_out_first,
    output logic result_out_first_oe_n,
    output logic result_out_second,
    output logic result_out_second_oe_n,
    output apm_pkg::apm_mode_e power_mode,
    output logic converter_ready
);

    logic [5:0] edge_count;
    logic drive_done;
    apm_pkg::apm_mode_e link_mode;
    logic mode_toggle;
    logic [2:0] toggle_sync;
    logic [17:0] wake_timer;

    // Bit shown on a line after a given number of falling edges: two
    // leading zeros, the own word, two zeros, two zeros, the other word.
    function automatic logic frame_bit(input logic [5:0] cnt,
                                       input logic [11:0] own,
                                       input logic [11:0] other);
        logic [5:0] idx;
        idx = 6'h00;
        frame_bit = 1'b0;
        if (cnt >= apm_pkg::APM_EDGE_GLITCH &&
            cnt <= apm_pkg::APM_WORD1_LAST) begin
            idx = apm_pkg::APM_WORD1_LAST - cnt;
            frame_bit = own[idx[3:0]];
        end else if (cnt >= apm_pkg::APM_WORD2_FIRST &&
                     cnt <= apm_pkg::APM_WORD2_LAST) begin
            idx = apm_pkg::APM_WORD2_LAST - cnt;
            frame_bit = other[idx[3:0]];
        end
    endfunction

    // Falling-edge counter, held clear while chip select is high. An edge
    // that meets the fall still sees the clear and so is not counted.
    always_ff @(negedge converter_serial_clock or posedge chip_select_n
                or negedge reset_n) begin
        if (!reset_n) begin
            edge_count <= 6'h00;
        end else if (chip_select_n) begin
            edge_count <= 6'h00;
        end else if (edge_count != apm_pkg::APM_EDGE_DUAL) begin
            edge_count <= edge_count + 6'h01;
        end
    end

    // Serial data: each line shifts its own result, then the other one.
    always_ff @(negedge converter_serial_clock or posedge chip_select_n
                or negedge reset_n) begin
        if (!reset_n) begin
            result_out_first <= 1'b0;
            result_out_second <= 1'b0;
        end else if (chip_select_n) begin
            result_out_first <= 1'b0;
            result_out_second <= 1'b0;
        end else begin
            result_out_first <= frame_bit(edge_count + 6'h01,
                conv_result.first, conv_result.second);
            result_out_second <= frame_bit(edge_count + 6'h01,
                conv_result.second, conv_result.first);
        end
    end

    // End of the dual read: the lines float on the thirty-second edge.
    always_ff @(negedge converter_serial_clock or posedge chip_select_n
                or negedge reset_n) begin
        if (!reset_n) begin
            drive_done <= 1'b0; // Set here, the first frame would float.
        end else if (chip_select_n) begin
            drive_done <= 1'b0;
        end else if (edge_count == apm_pkg::APM_EDGE_DUAL - 6'h01) begin
            drive_done <= 1'b1;
        end
    end

    // The lines must leave three-state at the fall itself, before any
    // serial clock edge, so the enable is a gate on chip select. A rise
    // floats both lines at once, which also covers every abort.
    assign result_out_first_oe_n = chip_select_n | drive_done;
    assign result_out_second_oe_n = chip_select_n | drive_done;

    // Mode decision, taken on the chip select rise from the count reached.
    // The toggle tells the system side that a new mode stands.
    always_ff @(posedge chip_select_n or negedge reset_n) begin
        if (!reset_n) begin
            link_mode <= apm_pkg::APM_NORMAL;
            mode_toggle <= 1'b0;
        end else begin
            mode_toggle <= ~mode_toggle;
            if (edge_count >= apm_pkg::APM_EDGE_KEEP) begin
                link_mode <= apm_pkg::APM_NORMAL;
            end else if (edge_count >= apm_pkg::APM_EDGE_GLITCH) begin
                unique case (link_mode)
                    apm_pkg::APM_NORMAL: begin
                        link_mode <= apm_pkg::APM_PARTIAL;
                    end
                    apm_pkg::APM_PARTIAL: begin
                        link_mode <= apm_pkg::APM_FULL;
                    end
                    apm_pkg::APM_FULL: begin
                        link_mode <= apm_pkg::APM_FULL;
                    end
                    default: begin
                        link_mode <= apm_pkg::APM_FULL;
                    end
                endcase
            end
        end
    end

    // Toggle crossing into the system clock; the mode word is stable for
    // a whole frame after the toggle moves, so it is read without a
    // synchroniser once the toggle has passed two flip-flops.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_sync <= 3'h0;
        end else begin
            toggle_sync <= {toggle_sync[1:0], mode_toggle};
        end
    end

    // Mode as seen by the system, and the analog wake-up wait that follows
    // a dummy frame. A wake from full power-down costs the long wait.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_mode <= apm_pkg::APM_NORMAL;
            wake_timer <= 18'h00000;
        end else if (toggle_sync[2] != toggle_sync[1]) begin
            power_mode <= link_mode;
            if (link_mode == apm_pkg::APM_NORMAL &&
                power_mode == apm_pkg::APM_FULL) begin
                wake_timer <= 18'(FULL_WAKE_CYCLES);
            end else if (link_mode == apm_pkg::APM_NORMAL &&
                         power_mode == apm_pkg::APM_PARTIAL) begin
                wake_timer <= 18'(apm_pkg::APM_PART_WAKE_CYC);
            end
        end else if (wake_timer != 18'h00000) begin
            wake_timer <= wake_timer - 18'h00001;
        end
    end

    // Ready only in normal mode once the wake-up wait has run out.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            converter_ready <= 1'b0;
        end else begin
            converter_ready <= (power_mode == apm_pkg::APM_NORMAL) &&
                               (wake_timer == 18'h00000);
        end
    end

    // Checks on the mode decision, taken from one rise to the next.
    stay_normal_a: assert property (@(posedge chip_select_n)
        disable iff (!reset_n)
        (edge_count < apm_pkg::APM_EDGE_GLITCH &&
         link_mode == apm_pkg::APM_NORMAL)
        |=> link_mode == apm_pkg::APM_NORMAL)
        else $error("Glitch on chip select changed normal mode.");

    enter_partial_a: assert property (@(posedge chip_select_n)
        disable iff (!reset_n)
        (edge_count >= apm_pkg::APM_EDGE_GLITCH &&
         edge_count < apm_pkg::APM_EDGE_KEEP &&
         link_mode == apm_pkg::APM_NORMAL)
        |=> link_mode == apm_pkg::APM_PARTIAL)
        else $error("Early rise did not enter partial power-down.");

    enter_full_a: assert property (@(posedge chip_select_n)
        disable iff (!reset_n)
        (edge_count >= apm_pkg::APM_EDGE_GLITCH &&
         edge_count < apm_pkg::APM_EDGE_KEEP &&
         link_mode == apm_pkg::APM_PARTIAL)
        |=> link_mode == apm_pkg::APM_FULL)
        else $error("Second early rise did not enter full power-down.");

    stay_partial_a: assert property (@(posedge chip_select_n)
        disable iff (!reset_n)
        (edge_count < apm_pkg::APM_EDGE_GLITCH &&
         link_mode == apm_pkg::APM_PARTIAL)
        |=> link_mode == apm_pkg::APM_PARTIAL)
        else $error("Glitch left partial power-down.");

    wake_normal_a: assert property (@(posedge chip_select_n)
        disable iff (!reset_n)
        edge_count >= apm_pkg::APM_EDGE_KEEP
        |=> link_mode == apm_pkg::APM_NORMAL)
        else $error("Frame past edge ten did not leave normal mode on.");

    // Checks on the serial data, sampled on the serial clock fall.
    lead_data_a: assert property (@(negedge converter_serial_clock)
        disable iff (chip_select_n || !reset_n)
        edge_count == apm_pkg::APM_EDGE_GLITCH
        |-> result_out_first == conv_result.first[11])
        else $error("First data bit not on the second edge.");

    trail_zero_a: assert property (@(negedge converter_serial_clock)
        disable iff (chip_select_n || !reset_n)
        (edge_count == apm_pkg::APM_EDGE_RESULT) ##1
        (edge_count == apm_pkg::APM_EDGE_RESULT + 6'h01)
        |-> !result_out_first && !$past(result_out_first))
        else $error("Trailing zeros missing after the result.");

    other_word_a: assert property (@(negedge converter_serial_clock)
        disable iff (chip_select_n || !reset_n)
        edge_count == apm_pkg::APM_WORD2_FIRST
        |-> result_out_first == conv_result.second[11] &&
            result_out_second == conv_result.first[11])
        else $error("Other result not presented on the same line.");

    keep_drive_a: assert property (@(negedge converter_serial_clock)
        disable iff (chip_select_n || !reset_n)
        (edge_count >= apm_pkg::APM_EDGE_RESULT &&
         edge_count < apm_pkg::APM_EDGE_DUAL)
        |-> !result_out_first_oe_n)
        else $error("Line floated before the rise after a result.");

    // Looked at on the rise after the last fall, which a host that stops
    // at thirty-two falls still gives.
    dual_float_a: assert property (@(posedge converter_serial_clock)
        disable iff (chip_select_n || !reset_n)
        edge_count == apm_pkg::APM_EDGE_DUAL
        |-> result_out_first_oe_n && result_out_second_oe_n)
        else $error("Line still driven after edge thirty-two.");

    // Checks on the system side; the link mode is stable when read.
    mode_follow_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        toggle_sync[2] != toggle_sync[1]
        |=> power_mode == link_mode)
        else $error("System mode did not follow the link mode.");

    full_load_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (toggle_sync[2] != toggle_sync[1] &&
         link_mode == apm_pkg::APM_NORMAL &&
         power_mode == apm_pkg::APM_FULL)
        |=> wake_timer == 18'(FULL_WAKE_CYCLES))
        else $error("Full wake wait not started after a dummy frame.");

    part_load_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (toggle_sync[2] != toggle_sync[1] &&
         link_mode == apm_pkg::APM_NORMAL &&
         power_mode == apm_pkg::APM_PARTIAL)
        |=> wake_timer == 18'(apm_pkg::APM_PART_WAKE_CYC))
        else $error("Short wake wait not started after a dummy frame.");

    wake_hold_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        wake_timer != 18'h00000 |=> !converter_ready)
        else $error("Ready rose while the wake wait was running.");

    // Main scenarios.
    partial_entry_c: cover property (@(posedge chip_select_n)
        disable iff (!reset_n)
        link_mode == apm_pkg::APM_PARTIAL);
    full_entry_c: cover property (@(posedge chip_select_n)
        disable iff (!reset_n)
        link_mode == apm_pkg::APM_FULL);
    dual_read_c: cover property (@(posedge converter_serial_clock)
        disable iff (chip_select_n || !reset_n)
        edge_count == apm_pkg::APM_EDGE_DUAL);
    glitch_frame_c: cover property (@(posedge chip_select_n)
        disable iff (!reset_n)
        edge_count < apm_pkg::APM_EDGE_GLITCH);
    abort_powered_c: cover property (@(posedge chip_select_n)
        disable iff (!reset_n)
        edge_count >= apm_pkg::APM_EDGE_KEEP &&
        edge_count < apm_pkg::APM_EDGE_RESULT);

endmodule

// ===== apm_pkg.sv
// Package for the ADC power-mode sequencer: modes, edge counts, timing.
// Assumes a 125 MHz system clock and a serial clock from the host.
package apm_pkg;

    // Operating modes of the converter.
    typedef enum logic [1:0] {
        APM_NORMAL,
        APM_PARTIAL,
        APM_FULL
    } apm_mode_e;

    // Results of both converters, as delivered by the conversion core.
    typedef struct packed {
        logic [11:0] first;
        logic [11:0] second;
    } apm_result_s;

    // Falling-edge counts that mark the decision points of a frame.
    localparam logic [5:0] APM_EDGE_GLITCH = 6'h02;
    localparam logic [5:0] APM_EDGE_KEEP = 6'h0A;
    localparam logic [5:0] APM_EDGE_RESULT = 6'h0E;
    localparam logic [5:0] APM_EDGE_TRAIL = 6'h10;
    localparam logic [5:0] APM_EDGE_DUAL = 6'h20;
    // First edge of the second 12-bit word and the last data edge of each.
    localparam logic [5:0] APM_WORD1_LAST = 6'h0D;
    localparam logic [5:0] APM_WORD2_FIRST = 6'h12;
    localparam logic [5:0] APM_WORD2_LAST = 6'h1D;

    // Wake-up times in their own units and the system clock rate.
    localparam int APM_CLK_MHZ = 125;
    localparam int APM_PART_WAKE_NS = 1000;
    localparam int APM_FULL_WAKE_US = 1500;
    // The partial wait rounds down; both stay above one cycle.
    localparam int APM_PART_WAKE_CYC = APM_PART_WAKE_NS * APM_CLK_MHZ / 1000;
    localparam int APM_FULL_WAKE_CYC = APM_FULL_WAKE_US * APM_CLK_MHZ;

endpackage

// ===== apm_host_model.sv
// Host serial controller model: frames chip select and the serial clock.
// Assumes the bench raises go for one system cycle per frame.
`timescale 1ns/1ps
module apm_host_model (
    input wire logic go,
    input wire logic coin,
    input wire logic [5:0] edges,
    input wire logic line_a,
    input wire logic oe_a_n,
    input wire logic line_b,
    input wire logic oe_b_n,
    output logic chip_select_n,
    output logic serial_clock,
    output logic busy,
    output logic [32:0] cap_a,
    output logic [32:0] cap_b,
    output logic [32:0] cap_oe_a,
    output logic [32:0] cap_oe_b
);
    // The serial clock idles high and stands still outside frames.
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b1;
        busy = 1'b0;
    end

    // One frame; each bit is sampled on the rise after the fall showing it.
    always @(posedge go) begin
        busy = 1'b1;
        cap_a = '0;
        cap_b = '0;
        cap_oe_a = '1;
        cap_oe_b = '1;
        // Chip select moves after the clock within the same step, so a
        // coincident fall reaches the device while chip select is high.
        #7 chip_select_n <= 1'b0;
        if (coin) serial_clock = 1'b0;
        for (int k = 0; k <= 32; k++) begin
            if (k > 0) begin
                if (k > edges) break;
                #15 serial_clock = 1'b0;
            end
            #15 serial_clock = 1'b1;
            cap_a[k] = line_a;
            cap_b[k] = line_b;
            cap_oe_a[k] = oe_a_n;
            cap_oe_b[k] = oe_b_n;
        end
        #5 chip_select_n <= 1'b1;
        #100 busy = 1'b0;
    end
endmodule

// ===== apm_adc_power_mode_sequencer_bench.sv
// Self-checking bench of the power-mode sequencer.
// Assumes the host model frames chip select at a 30 ns serial clock.
`timescale 1ns/1ps
module apm_adc_power_mode_sequencer_bench;
    localparam int WAKE = 50;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic go = 1'b0;
    logic coin = 1'b0;
    logic [5:0] edges = 6'h00;
    logic cs_n, sclk, busy, la, la_oe_n, lb, lb_oe_n, ready;
    logic [32:0] cap_a, cap_b, oe_a, oe_b;
    apm_pkg::apm_mode_e mode;
    apm_pkg::apm_result_s res = '{first: 12'hA5C, second: 12'h3B1};
    int err_count = 0;
    int cmp_count = 0;

    // System clock at 125 MHz.
    initial forever #4 sys_clk = ~sys_clk;

    apm_adc_power_mode_sequencer #(.FULL_WAKE_CYCLES(WAKE)) DUT (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .converter_serial_clock(sclk), .chip_select_n(cs_n),
        .conv_result(res), .result_out_first(la),
        .result_out_first_oe_n(la_oe_n), .result_out_second(lb),
        .result_out_second_oe_n(lb_oe_n), .power_mode(mode),
        .converter_ready(ready));

    apm_host_model host (
        .go(go), .coin(coin), .edges(edges), .line_a(la), .oe_a_n(la_oe_n),
        .line_b(lb), .oe_b_n(lb_oe_n), .chip_select_n(cs_n),
        .serial_clock(sclk), .busy(busy), .cap_a(cap_a), .cap_b(cap_b),
        .cap_oe_a(oe_a), .cap_oe_b(oe_b));

    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_vec(input string n, input logic [32:0] e,
                           input logic [32:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_mode(input apm_pkg::apm_mode_e e);
        cmp_count++;
        if (mode !== e) begin
            err_count++;
            $display("CHECK FAILED power_mode expected %0d seen %0d", e, mode);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask

    // Expected serial line for a frame of n falls: leading and trailing zeros.
    function automatic logic [32:0] line_of(input logic [11:0] own,
                                            input logic [11:0] other,
                                            input int n);
        logic [32:0] v;
        v = '0;
        for (int k = 2; k <= 13; k++) if (k <= n) v[k] = own[13-k];
        for (int k = 18; k <= 29; k++) if (k <= n) v[k] = other[29-k];
        return v;
    endfunction

    // One frame, held until the host model reports it idle again.
    task automatic frame(input logic [5:0] n, input logic c);
        int t;
        @(negedge sys_clk);
        edges = n;
        coin = c;
        go = 1'b1;
        @(negedge sys_clk);
        go = 1'b0;
        t = 0;
        while (busy !== 1'b0 && t < 400) begin
            @(negedge sys_clk);
            t++;
        end
        if (t >= 400) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    // Ready must come back within the wake time, not long before it.
    task automatic wake(input int w);
        int t;
        t = 0;
        chk_bit("ready_low", 1'b0, ready);
        while (ready !== 1'b1 && t < 2000) begin
            @(negedge sys_clk);
            t++;
        end
        if (t >= 2000) begin
            err_count++;
            tally_and_finish();
        end
        chk_bit("wake_time", 1'b1, t >= w - 20 && t <= w);
    endtask

    task automatic t_dual_read();
        frame(6'h20, 1'b0);
        chk_vec("line_a", line_of(res.first, res.second, 32), {1'b0, cap_a[31:0]});
        chk_vec("line_b", line_of(res.second, res.first, 32), {1'b0, cap_b[31:0]});
        chk_vec("oe_a", 33'h100000000, oe_a);
        chk_vec("oe_b", 33'h100000000, oe_b);
        chk_mode(apm_pkg::APM_NORMAL);
    endtask

    task automatic t_coincident();
        frame(6'h0E, 1'b1);
        chk_vec("coin_a", line_of(res.first, res.second, 14), {1'b0, cap_a[31:0]});
        chk_vec("coin_oe", 33'h1FFFF8000, oe_a);
    endtask

    task automatic t_power_down();
        frame(6'h01, 1'b0);
        chk_mode(apm_pkg::APM_NORMAL);
        chk_bit("ready", 1'b1, ready);
        frame(6'h02, 1'b0);
        chk_mode(apm_pkg::APM_PARTIAL);
        chk_bit("oe_released", 1'b1, la_oe_n & lb_oe_n);
        frame(6'h01, 1'b0);
        chk_mode(apm_pkg::APM_PARTIAL);
        frame(6'h09, 1'b0);
        chk_mode(apm_pkg::APM_FULL);
        frame(6'h03, 1'b0);
        chk_mode(apm_pkg::APM_FULL);
    endtask

    task automatic t_wake_up();
        frame(6'h0C, 1'b0);
        chk_mode(apm_pkg::APM_NORMAL);
        chk_bit("abort_float", 1'b1, la_oe_n & lb_oe_n);
        wake(WAKE);
        frame(6'h05, 1'b0);
        frame(6'h0A, 1'b0);
        chk_mode(apm_pkg::APM_NORMAL);
        wake(125);
    endtask

    // Reset for six cycles, then run every scenario in turn.
    initial begin
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_dual_read();
        t_coincident();
        t_power_down();
        t_wake_up();
        tally_and_finish();
    end
endmodule
